/* clock_sleep_pkg.sv */
// constants, types and decode helpers of the clock prescaler and sleep control
// assumes a single master clock and a 32-bit AXI4-Lite register bus
`default_nettype none

package clock_sleep_pkg;

    // ************************************************************
    // register map
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CLOCK_DIVIDE = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_SLEEP_CONTROL = 8'h04;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h08;

    localparam int UNLOCK_BIT = 7;
    localparam int SEL_LSB = 0;
    localparam int SEL_W = 4;
    localparam int SLEEP_ALLOW_BIT = 0;
    localparam int KIND_LSB = 1;
    localparam int KIND_W = 3;
    localparam int STAT_SEL_LSB = 0;
    localparam int STAT_STATE_LSB = 4;
    localparam int STAT_KIND_LSB = 6;

    localparam logic [7:0] SLEEP_CONTROL_RESET = 8'h00;
    localparam logic [SEL_W-1:0] SEL_RESET_PLAIN = 4'h0;
    localparam logic [SEL_W-1:0] SEL_RESET_FUSE = 4'h3;
    localparam logic [SEL_W-1:0] SEL_MAX = 4'h8;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ************************************************************
    // timing counts in master clock cycles
    // ************************************************************
    localparam logic [2:0] UNLOCK_WINDOW_CYC = 3'h4;
    localparam logic [15:0] WAKE_HOLD_CYC = 16'h0004;
    localparam logic [15:0] STANDBY_WAKE_CYC = 16'h0006;
    localparam int POWER_DOWN_STARTUP_CYC = 1024;
    localparam logic [1:0] FUSE_SETTLE_CYC = 2'h2;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [KIND_W-1:0] {
        KIND_IDLE = 3'h0,
        KIND_ADC_QUIET = 3'h1,
        KIND_POWER_DOWN = 3'h2,
        KIND_STANDBY = 3'h6
    } sleep_kind_t;

    typedef enum logic [1:0] {
        ST_RUN = 2'h0,
        ST_ASLEEP = 2'h1,
        ST_STARTUP = 2'h3,
        ST_HOLD = 2'h2
    } power_state_t;

    typedef struct packed {
        logic ext_edge;
        logic ext_level;
        logic timer;
        logic io_other;
        logic adc_done;
        logic mem_ready;
        logic psc;
        logic wdt;
    } wake_src_t;

    typedef struct packed {
        logic cpu;
        logic flash;
        logic io;
        logic adc;
    } clk_en_t;

    // ************************************************************
    // decode helpers
    // ************************************************************
    function automatic logic kind_valid(input logic [KIND_W-1:0] k);
        return k == KIND_IDLE || k == KIND_ADC_QUIET || k == KIND_POWER_DOWN || k == KIND_STANDBY;
    endfunction : kind_valid

    function automatic wake_src_t wake_mask(input logic [KIND_W-1:0] k);
        wake_src_t m;
        m = '0;
        case (k)
            KIND_IDLE: m = '1;
            KIND_ADC_QUIET: begin
                m.ext_level = 1'b1;
                m.timer = 1'b1;
                m.adc_done = 1'b1;
                m.mem_ready = 1'b1;
                m.wdt = 1'b1;
            end
            KIND_POWER_DOWN: begin
                m.ext_level = 1'b1;
                m.psc = 1'b1;
                m.wdt = 1'b1;
            end
            KIND_STANDBY: begin
                m.ext_level = 1'b1;
                m.wdt = 1'b1;
            end
            default: m = '0;
        endcase
        return m;
    endfunction : wake_mask

    function automatic clk_en_t sleep_clocks(input logic [KIND_W-1:0] k);
        clk_en_t c;
        c = '0;
        case (k)
            KIND_IDLE: c = '{cpu: 1'b0, flash: 1'b0, io: 1'b1, adc: 1'b1};
            KIND_ADC_QUIET: c = '{cpu: 1'b0, flash: 1'b0, io: 1'b0, adc: 1'b1};
            default: c = '0;
        endcase
        return c;
    endfunction : sleep_clocks

endpackage : clock_sleep_pkg

`default_nettype wire

/* prescaler_divider.sv */
// power-of-two divider producing a one-cycle tick at the divided rate
// assumes i_run stays low until the divide select value is valid
`timescale 1ns/100ps
`default_nettype none

module prescaler_divider
    import clock_sleep_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_run,
    input wire logic [SEL_W-1:0] i_sel,
    output logic o_tick,
    output logic [SEL_W-1:0] o_active_sel
);

    logic [7:0] cnt;
    logic [7:0] mask;
    logic [SEL_W-1:0] eff;
    logic tick;

    // reserved codes divide like the largest factor
    assign eff = (o_active_sel > SEL_MAX) ? SEL_MAX : o_active_sel;
    assign mask = 8'((9'h001 << eff) - 9'h001);
    assign tick = (cnt == mask);

    // while running, new factor only taken at an old period boundary, so no short pulse
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            cnt <= 8'h00;
            o_active_sel <= 4'h0;
            o_tick <= 1'b0;
        end else if (!i_run) begin
            cnt <= 8'h00;
            o_active_sel <= i_sel;
            o_tick <= 1'b0;
        end else begin
            o_tick <= tick;
            if (tick) begin
                cnt <= 8'h00;
                o_active_sel <= i_sel;
            end else begin
                cnt <= cnt + 8'h01;
            end
        end
    end

endmodule : prescaler_divider

`default_nettype wire

/* divide_unlock.sv */
// divide select register with its timed change unlock
// assumes i_we is a one-cycle strobe carrying the written byte
`timescale 1ns/100ps
`default_nettype none

module divide_unlock
    import clock_sleep_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_load,
    input wire logic i_fuse,
    input wire logic i_we,
    input wire logic [7:0] i_wdata,
    output logic o_unlock,
    output logic [SEL_W-1:0] o_sel
);

    logic [2:0] left;
    logic arm;
    logic change;

    assign arm = i_we && i_wdata[UNLOCK_BIT] && (i_wdata[6:0] == 7'h00);
    assign change = i_we && o_unlock && !i_wdata[UNLOCK_BIT];

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_unlock <= 1'b0;
            left <= 3'h0;
        end else if (change) begin
            o_unlock <= 1'b0;
        end else if (arm && !o_unlock) begin
            o_unlock <= 1'b1;
            left <= UNLOCK_WINDOW_CYC - 3'h1;
        end else if (o_unlock) begin
            // a second arm write neither restarts nor ends the window
            if (left == 3'h0) begin
                o_unlock <= 1'b0;
            end else begin
                left <= left - 3'h1;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_sel <= SEL_RESET_PLAIN;
        end else if (i_load) begin
            o_sel <= i_fuse ? SEL_RESET_FUSE : SEL_RESET_PLAIN;
        end else if (change) begin
            o_sel <= i_wdata[SEL_LSB +: SEL_W];
        end
    end

endmodule : divide_unlock

`default_nettype wire

/* clock_sleep_ctrl.sv */
// top of the clock prescaler and sleep control: bus slave, sleep sequencer
// assumes the core pulses i_sleep_instr on the master clock; wake sources are async
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module clock_sleep_ctrl
    import clock_sleep_pkg::*;
#(
    parameter int STARTUP_CYCLES = POWER_DOWN_STARTUP_CYC
)
(
    input wire logic i_core_clk,
    input wire logic i_resetn,
    // axi4-lite slave
    input wire logic [ADDR_W-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [ADDR_W-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready,
    // device side
    input wire logic i_start_divide_by_eight_fuse,
    input wire logic i_sleep_instr,
    input wire logic i_adc_enabled,
    input wire wake_src_t i_wake_src,
    output clk_en_t o_clk_en,
    output logic o_osc_run,
    output logic o_adc_start,
    output logic o_wake_irq,
    output logic o_sleeping
);

    // ************************************************************
    // declarations
    // ************************************************************
    logic fuse_s1;
    logic fuse_s2;
    logic [1:0] init_cnt;
    logic fuse_load;
    logic sel_ready;
    wake_src_t wake_s1;
    wake_src_t wake_s2;

    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic wr_fire;
    logic div_we;

    logic unlock;
    logic [SEL_W-1:0] divide_select;
    logic [SEL_W-1:0] active_sel;
    logic tick;

    logic sleep_allow;
    logic [KIND_W-1:0] sleep_kind_select;
    logic [KIND_W-1:0] kind_act;
    power_state_t state;
    logic [15:0] wait_cnt;
    logic wake_hit;
    clk_en_t allowed;
    logic [31:0] status_word;

    // ************************************************************
    // input synchronisers and fuse capture
    // ************************************************************
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            fuse_s1 <= 1'b0;
            fuse_s2 <= 1'b0;
            wake_s1 <= '0;
            wake_s2 <= '0;
        end else begin
            fuse_s1 <= i_start_divide_by_eight_fuse;
            fuse_s2 <= fuse_s1;
            wake_s1 <= i_wake_src;
            wake_s2 <= wake_s1;
        end
    end

    // fuse is sampled once the synchroniser has settled after release
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            init_cnt <= 2'h0;
        end else if (init_cnt != 2'h3) begin
            init_cnt <= init_cnt + 2'h1;
        end
    end

    assign fuse_load = (init_cnt == FUSE_SETTLE_CYC);
    assign sel_ready = (init_cnt == 2'h3);

    // ************************************************************
    // axi4-lite write channel
    // ************************************************************
    assign wr_fire = aw_got && w_got && !o_bvalid;
    assign div_we = wr_fire && wr_strb[0] && (wr_addr == ADDR_CLOCK_DIVIDE);

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            aw_got <= 1'b0;
            o_awready <= 1'b1;
            wr_addr <= '0;
        end else if (i_awvalid && o_awready) begin
            aw_got <= 1'b1;
            o_awready <= 1'b0;
            wr_addr <= i_awaddr;
        end else if (wr_fire) begin
            aw_got <= 1'b0;
            o_awready <= 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            w_got <= 1'b0;
            o_wready <= 1'b1;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
        end else if (i_wvalid && o_wready) begin
            w_got <= 1'b1;
            o_wready <= 1'b0;
            wr_data <= i_wdata;
            wr_strb <= i_wstrb;
        end else if (wr_fire) begin
            w_got <= 1'b0;
            o_wready <= 1'b1;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_bvalid <= 1'b0;
            o_bresp <= RESP_OKAY;
        end else if (wr_fire) begin
            o_bvalid <= 1'b1;
            if (wr_addr == ADDR_CLOCK_DIVIDE || wr_addr == ADDR_SLEEP_CONTROL ||
                wr_addr == ADDR_STATUS) begin
                o_bresp <= RESP_OKAY;
            end else begin
                o_bresp <= RESP_SLVERR;
            end
        end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    // ************************************************************
    // axi4-lite read channel
    // ************************************************************
    assign status_word = {23'h000000, kind_act, state, active_sel};

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_arready <= 1'b1;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rresp <= RESP_OKAY;
            case (i_araddr)
                ADDR_CLOCK_DIVIDE: o_rdata <= {24'h000000, unlock, 3'h0, divide_select};
                ADDR_SLEEP_CONTROL: o_rdata <= {28'h0000000, sleep_kind_select, sleep_allow};
                ADDR_STATUS: o_rdata <= status_word;
                default: begin
                    o_rdata <= 32'h0000_0000;
                    o_rresp <= RESP_SLVERR;
                end
            endcase
        end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
            o_arready <= 1'b1;
        end
    end

    // ************************************************************
    // divider register, unlock and prescaler
    // ************************************************************
    divide_unlock u_unlock (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_load(fuse_load),
        .i_fuse(fuse_s2),
        .i_we(div_we),
        .i_wdata(wr_data[7:0]),
        .o_unlock(unlock),
        .o_sel(divide_select)
    );

    prescaler_divider u_divider (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_run(sel_ready),
        .i_sel(divide_select),
        .o_tick(tick),
        .o_active_sel(active_sel)
    );

    // ************************************************************
    // sleep control register
    // ************************************************************
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sleep_allow <= SLEEP_CONTROL_RESET[SLEEP_ALLOW_BIT];
            sleep_kind_select <= SLEEP_CONTROL_RESET[KIND_LSB +: KIND_W];
        end else if (wr_fire && wr_strb[0] && wr_addr == ADDR_SLEEP_CONTROL) begin
            sleep_allow <= wr_data[SLEEP_ALLOW_BIT];
            sleep_kind_select <= wr_data[KIND_LSB +: KIND_W];
        end
    end

    // ************************************************************
    // sleep sequencer
    // ************************************************************
    assign wake_hit = |(wake_s2 & wake_mask(kind_act));

    // reset returns straight to run, so the core restarts at its reset vector
    // nothing here touches core storage; stopped clocks keep it intact
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state <= ST_RUN;
            kind_act <= KIND_IDLE;
            wait_cnt <= 16'h0000;
        end else begin
            case (state)
                ST_RUN: begin
                    if (i_sleep_instr && sleep_allow && kind_valid(sleep_kind_select)) begin
                        state <= ST_ASLEEP;
                        kind_act <= sleep_kind_select;
                    end
                end
                ST_ASLEEP: begin
                    if (wake_hit) begin
                        if (kind_act == KIND_POWER_DOWN) begin
                            state <= ST_STARTUP;
                            wait_cnt <= 16'(STARTUP_CYCLES - 1);
                        end else if (kind_act == KIND_STANDBY) begin
                            state <= ST_STARTUP;
                            wait_cnt <= STANDBY_WAKE_CYC - 16'h0001;
                        end else begin
                            state <= ST_HOLD;
                            wait_cnt <= WAKE_HOLD_CYC - 16'h0001;
                        end
                    end
                end
                ST_STARTUP: begin
                    if (wait_cnt == 16'h0000) begin
                        state <= ST_HOLD;
                        wait_cnt <= WAKE_HOLD_CYC - 16'h0001;
                    end else begin
                        wait_cnt <= wait_cnt - 16'h0001;
                    end
                end
                ST_HOLD: begin
                    if (wait_cnt == 16'h0000) begin
                        state <= ST_RUN;
                    end else begin
                        wait_cnt <= wait_cnt - 16'h0001;
                    end
                end
                default: state <= ST_RUN;
            endcase
        end
    end

    // ************************************************************
    // clock gating per state
    // ************************************************************
    always_comb begin
        case (state)
            ST_RUN: allowed = '1;
            ST_ASLEEP: allowed = sleep_clocks(kind_act);
            ST_HOLD: allowed = '{cpu: 1'b0, flash: 1'b0, io: 1'b1, adc: 1'b1};
            default: allowed = '0;
        endcase
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_clk_en <= '0;
        end else begin
            o_clk_en <= tick ? allowed : '0;
        end
    end

    // ************************************************************
    // status outputs and event pulses
    // ************************************************************
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_osc_run <= 1'b1;
        end else begin
            o_osc_run <= !(state == ST_ASLEEP && kind_act == KIND_POWER_DOWN);
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_adc_start <= 1'b0;
        end else begin
            o_adc_start <= (state == ST_RUN) && i_sleep_instr && sleep_allow && i_adc_enabled &&
                (sleep_kind_select == KIND_IDLE || sleep_kind_select == KIND_ADC_QUIET);
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_wake_irq <= 1'b0;
        end else begin
            o_wake_irq <= (state == ST_HOLD) && (wait_cnt == 16'h0000);
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_sleeping <= 1'b0;
        end else begin
            o_sleeping <= (state != ST_RUN);
        end
    end

endmodule : clock_sleep_ctrl

`default_nettype wire

/* clock_sleep_ctrl_monitor.sv */
// port assertions of clock_sleep_ctrl
// assumes one master clock domain; bound in below
`timescale 1ns/100ps
`default_nettype none
module clock_sleep_ctrl_monitor
    import clock_sleep_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_arvalid,
    input wire logic o_arready,
    input wire logic o_rvalid,
    input wire logic i_rready,
    input wire logic [31:0] o_rdata,
    input wire logic o_bvalid,
    input wire logic i_bready,
    input wire logic [1:0] o_bresp,
    input wire logic i_sleep_instr,
    input wire logic i_adc_enabled,
    input wire clk_en_t o_clk_en,
    input wire logic o_osc_run,
    input wire logic o_adc_start,
    input wire logic o_wake_irq,
    input wire logic o_sleeping
);
    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_resetn);
    sequence s_enter;
        i_sleep_instr ##2 $rose(o_sleeping);
    endsequence
    chk_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
        else $error("read not answered");
    chk_read_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
        else $error("read data dropped");
    chk_write_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
        else $error("write response dropped");
    chk_clk_shared: assert property (o_clk_en.cpu |-> o_clk_en.flash && o_clk_en.io)
        else $error("core clock without the others");
    chk_io_adc: assert property (o_clk_en.io |-> o_clk_en.adc)
        else $error("io clock without converter clock");
    chk_asleep_gate: assert property (o_sleeping [*3] |-> !o_clk_en.cpu && !o_clk_en.flash)
        else $error("core clock while asleep");
    chk_osc_awake: assert property (!o_sleeping |-> o_osc_run)
        else $error("oscillator off while running");
    chk_sleep_cause: assert property ($rose(o_sleeping) |-> $past(i_sleep_instr, 2))
        else $error("sleep without instruction");
    chk_sleep_hold: assert property (s_enter |=> o_sleeping [*3])
        else $error("wake too early");
    chk_adc_start: assert property (o_adc_start |-> $past(i_adc_enabled) ##1 o_sleeping)
        else $error("stray conversion start");
    chk_wake_irq: assert property (o_wake_irq |=> $fell(o_sleeping))
        else $error("wake pulse out of place");
endmodule : clock_sleep_ctrl_monitor

bind clock_sleep_ctrl clock_sleep_ctrl_monitor i_mon (.*);
`default_nettype wire

/* testbench.sv */
// self-checking bench of clock_sleep_ctrl over axi4-lite
// assumes package, design and monitor compiled first
`timescale 1ns/100ps
`default_nettype none
module testbench;
    import clock_sleep_pkg::*;
    logic i_core_clk, i_resetn, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_osc_run, o_adc_start;
    logic o_wake_irq, o_sleeping, i_start_divide_by_eight_fuse, i_sleep_instr, i_adc_enabled;
    logic [ADDR_W-1:0] i_awaddr, i_araddr;
    logic [31:0] i_wdata, o_rdata, rd_val;
    logic [3:0] i_wstrb;
    logic [1:0] o_bresp, o_rresp, rd_resp;
    wake_src_t i_wake_src;
    clk_en_t o_clk_en;
    int miscompares = 0;
    int cmp_count = 0;
    // ************************************************************
    // design, clock, tasks
    // ************************************************************
    clock_sleep_ctrl #(.STARTUP_CYCLES(8)) i_dut (.*);
    initial begin
        i_core_clk = 1'b0;
        forever #12.5 i_core_clk = ~i_core_clk;
    end
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic slow);
        int n;
        i_awaddr <= a;
        i_wdata <= d;
        i_awvalid <= 1'b1;
        i_wvalid <= 1'b1;
        i_bready <= !slow;
        for (n = 0; n < 50; n++) begin
            @(posedge i_core_clk);
            if (o_awready && i_awvalid) i_awvalid <= 1'b0;
            if (o_wready && i_wvalid) i_wvalid <= 1'b0;
            if (o_bvalid && i_bready) break;
            if (o_bvalid) i_bready <= 1'b1;
        end
        chk("write done", n < 50, 1'b1);
        if (n == 50) report_and_stop();
        chk("bresp", o_bresp, RESP_OKAY);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        int n;
        i_araddr <= a;
        i_arvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge i_core_clk);
            if (o_arready) i_arvalid <= 1'b0;
            if (o_rvalid && i_rready) break;
            if (o_rvalid) i_rready <= 1'b1;
        end
        chk("read done", n < 50, 1'b1);
        if (n == 50) report_and_stop();
        rd_val = o_rdata;
        rd_resp = o_rresp;
        i_rready <= 1'b0;
    endtask : rd
    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk("register", rd_val, e);
    endtask : rc
    task automatic div(input logic [3:0] d);
        wr(ADDR_CLOCK_DIVIDE, 32'h80, 1'b0);
        wr(ADDR_CLOCK_DIVIDE, {28'h0, d}, 1'b0);
    endtask : div
    task automatic gap(input int e);
        int k;
        for (k = 0; o_clk_en.cpu !== 1'b1 && k < 600; k++) @(posedge i_core_clk);
        k = 0;
        do begin
            @(posedge i_core_clk);
            k++;
        end while (o_clk_en.cpu !== 1'b1 && k < 600);
        chk("clock gap", k, e);
        if (k == 600) report_and_stop();
    endtask : gap
    task automatic sleep_in(input logic [7:0] s);
        wr(ADDR_SLEEP_CONTROL, {24'h0, s}, 1'b1);
        i_sleep_instr <= 1'b1;
        @(posedge i_core_clk);
        i_sleep_instr <= 1'b0;
        repeat (3) @(posedge i_core_clk);
    endtask : sleep_in
    task automatic nap(input logic [7:0] s, input wake_src_t bad, input wake_src_t w,
        input logic sl, input logic osc, input clk_en_t ce);
        int n;
        sleep_in(s);
        chk("osc", o_osc_run, osc);
        i_wake_src <= bad;
        repeat (10) @(posedge i_core_clk);
        chk("asleep", o_sleeping, sl);
        chk("clock enables", o_clk_en, ce);
        i_wake_src <= w;
        for (n = 0; n < 60 && o_sleeping !== 1'b0; n++) @(posedge i_core_clk);
        chk("woken", n < 60, 1'b1);
        if (n == 60) report_and_stop();
        i_wake_src <= '0;
        wr(ADDR_SLEEP_CONTROL, 32'h00, 1'b0);
    endtask : nap
    // ************************************************************
    // sequence
    // ************************************************************
    initial begin
        {i_awaddr, i_araddr, i_wdata, i_awvalid, i_wvalid, i_bready, i_arvalid} = '0;
        {i_rready, i_sleep_instr, i_wake_src, i_resetn} = '0;
        i_wstrb = 4'hF;
        i_adc_enabled = 1'b1;
        i_start_divide_by_eight_fuse = 1'b1;
        repeat (10) @(posedge i_core_clk);
        i_resetn <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        rc(ADDR_CLOCK_DIVIDE, 32'h03);
        rc(ADDR_SLEEP_CONTROL, 32'h00);
        rc(8'h0C, 32'h00);
        chk("rresp", rd_resp, RESP_SLVERR);
        gap(8);
        wr(ADDR_CLOCK_DIVIDE, 32'h05, 1'b1);
        rc(ADDR_CLOCK_DIVIDE, 32'h03);
        wr(ADDR_CLOCK_DIVIDE, 32'h81, 1'b0);
        wr(ADDR_CLOCK_DIVIDE, 32'h05, 1'b0);
        rc(ADDR_CLOCK_DIVIDE, 32'h03);
        wr(ADDR_CLOCK_DIVIDE, 32'h80, 1'b0);
        div(4'h5);
        rc(ADDR_CLOCK_DIVIDE, 32'h03);
        for (int c = 8; c >= 0; c--) begin
            div(c[3:0]);
            for (int n = 0; n < 300 && rd_val[3:0] !== c[3:0]; n++) rd(ADDR_STATUS);
            chk("active divide", rd_val[3:0], c[3:0]);
            gap(1 << c);
        end
        nap(8'h01, 8'h00, 8'h20, 1'b1, 1'b1, 4'h3);
        i_adc_enabled <= 1'b0;
        nap(8'h03, 8'h12, 8'h08, 1'b1, 1'b1, 4'h1);
        nap(8'h05, 8'h20, 8'h40, 1'b1, 1'b0, 4'h0);
        nap(8'h0D, 8'h20, 8'h01, 1'b1, 1'b1, 4'h0);
        nap(8'h07, 8'h00, 8'h00, 1'b0, 1'b1, 4'hF);
        nap(8'h04, 8'h00, 8'h00, 1'b0, 1'b1, 4'hF);
        sleep_in(8'h05);
        i_start_divide_by_eight_fuse <= 1'b0;
        i_resetn <= 1'b0;
        @(posedge i_core_clk);
        chk("asleep", o_sleeping, 1'b0);
        i_resetn <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        rc(ADDR_CLOCK_DIVIDE, 32'h00);
        rc(ADDR_SLEEP_CONTROL, 32'h00);
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
